// ---- dmaec_pkg.sv ----
// constants, field layout and carrier types of the dma channel event control block
// assumes a single 125 mhz clock domain shared with the interrupt sources and the engine
package dmaec_pkg;

  // clock
  localparam int CLK_PERIOD_NS = 8;

  // register byte offsets
  localparam logic [7:0] OFS_EVENT_CTRL = 8'h00;
  localparam logic [7:0] OFS_SRC_PTR    = 8'h04;
  localparam logic [7:0] OFS_DST_PTR    = 8'h08;
  localparam logic [7:0] OFS_CHAN_CTRL  = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h14;
  localparam logic [7:0] OFS_SRC_SIZE   = 8'h18;
  localparam logic [7:0] OFS_DST_SIZE   = 8'h1c;

  // event control fields
  localparam int ABORT_SEL_LSB = 16;
  localparam int START_SEL_LSB = 8;
  localparam int FORCE_BIT     = 7;
  localparam int ABORT_BIT     = 6;
  localparam int PAT_EN_BIT    = 5;
  localparam int START_EN_BIT  = 4;
  localparam int ABORT_EN_BIT  = 3;
  localparam logic [7:0] SEL_RST = 8'hff;

  // channel control fields
  localparam int CHAN_EN_BIT   = 0;
  localparam int CHAN_BUSY_BIT = 1;

  // interrupt status layout, mask has the same layout
  localparam int IRQ_W         = 6;
  localparam int ST_ABORT_FLAG = 0;
  localparam int ST_STARTED    = 1;
  localparam int ST_PAT_ABORT  = 2;
  localparam int ST_CELL_DONE  = 3;
  localparam int ST_SRC_WRAP   = 4;
  localparam int ST_DST_WRAP   = 5;
  localparam logic [IRQ_W-1:0] IRQ_RST = 6'h00;

  // pointers: a size of zero stands for the whole 64 kbyte span
  localparam int PTR_W = 16;
  localparam logic [PTR_W-1:0] PTR_RST  = 16'h0000;
  localparam logic [PTR_W-1:0] SIZE_RST = 16'h0000;
  localparam logic [PTR_W:0]   PTR_SPAN = 17'h10000;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic {CH_IDLE, CH_BUSY} dmaec_chan_e;

  typedef struct packed {
    logic       valid;
    logic [7:0] num;
  } dmaec_irq_evt_s;

  typedef struct packed {
    logic             src_adv;
    logic [PTR_W-1:0] src_bytes;
    logic             dst_adv;
    logic [PTR_W-1:0] dst_bytes;
    logic             pattern_hit;
    logic             cell_done;
  } dmaec_eng_s;

  typedef struct packed {
    logic start;
    logic abort;
    logic channel_enable;
    logic busy;
  } dmaec_ctl_s;

endpackage

// ---- dmaec_ptr.sv ----
// byte pointer of one buffer: advances by the bytes moved and wraps at the buffer size
// assumes advance requests come from engine logic on the same clock
`timescale 1ns/10ps
module dmaec_ptr (
  // clock and reset
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // control
  input  wire logic                         clear,
  input  wire logic                         adv,
  input  wire logic [dmaec_pkg::PTR_W-1:0]  bytes,
  input  wire logic [dmaec_pkg::PTR_W-1:0]  size,
  // state
  output logic      [dmaec_pkg::PTR_W-1:0]  ptr_r,
  output logic                              wrap_r
);

  logic [dmaec_pkg::PTR_W:0] sum;
  logic [dmaec_pkg::PTR_W:0] limit;
  logic                      hit;

  assign sum   = {1'b0, ptr_r} + {1'b0, bytes};
  assign limit = (size == dmaec_pkg::SIZE_RST) ? dmaec_pkg::PTR_SPAN : {1'b0, size};
  assign hit   = adv & (sum >= limit);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_r <= dmaec_pkg::PTR_RST;
    end else if (clear || hit) begin
      ptr_r <= dmaec_pkg::PTR_RST;
    end else if (adv) begin
      ptr_r <= sum[dmaec_pkg::PTR_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wrap_r <= 1'b0;
    end else begin
      wrap_r <= hit;
    end
  end

endmodule

// ---- dmaec_top.sv ----
// event control and pointer status of one dma channel, with an axi4-lite register slave
// assumes interrupt events and engine reports are synchronous to aclk
`timescale 1ns/10ps
module dmaec_top (
  // clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // axi4-lite write address
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // interrupt request sources
  input  wire dmaec_pkg::dmaec_irq_evt_s irq_evt,
  // transfer engine
  input  wire dmaec_pkg::dmaec_eng_s   eng,
  output dmaec_pkg::dmaec_ctl_s        ctl_r,
  // interrupt
  output logic                         irq_r
);

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic [7:0]                       abort_sel_r;
  logic [7:0]                       start_sel_r;
  logic                             pat_en_r;
  logic                             start_en_r;
  logic                             abort_en_r;
  logic                             chan_en_r;
  logic [dmaec_pkg::IRQ_W-1:0]      status_r;
  logic [dmaec_pkg::IRQ_W-1:0]      mask_r;
  logic [dmaec_pkg::PTR_W-1:0]      src_size_r;
  logic [dmaec_pkg::PTR_W-1:0]      dst_size_r;
  logic [dmaec_pkg::PTR_W-1:0]      src_ptr;
  logic [dmaec_pkg::PTR_W-1:0]      dst_ptr;
  logic                             src_wrap;
  logic                             dst_wrap;
  dmaec_pkg::dmaec_chan_e           state_r;

  ////////////////////////////////////////////////////////////////////////////
  // axi write channel: address and data taken in either order

  logic        aw_hold_r;
  logic        w_hold_r;
  logic [7:0]  wr_addr_r;
  logic [31:0] wr_data_r;
  logic [3:0]  wr_strb_r;
  logic        wr_fire;
  logic        wr_ok;

  assign wr_fire = aw_hold_r & w_hold_r & ~s_axi_bvalid;

  always_comb begin
    unique case (wr_addr_r)
      dmaec_pkg::OFS_EVENT_CTRL,
      dmaec_pkg::OFS_SRC_PTR,
      dmaec_pkg::OFS_DST_PTR,
      dmaec_pkg::OFS_CHAN_CTRL,
      dmaec_pkg::OFS_IRQ_STATUS,
      dmaec_pkg::OFS_IRQ_MASK,
      dmaec_pkg::OFS_SRC_SIZE,
      dmaec_pkg::OFS_DST_SIZE: wr_ok = 1'b1;
      default:                 wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r     <= 1'b0;
      s_axi_awready <= 1'b1;
      wr_addr_r     <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_r     <= 1'b1;
      s_axi_awready <= 1'b0;
      wr_addr_r     <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_hold_r     <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_r     <= 1'b0;
      s_axi_wready <= 1'b1;
      wr_data_r    <= 32'h00000000;
      wr_strb_r    <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_r     <= 1'b1;
      s_axi_wready <= 1'b0;
      wr_data_r    <= s_axi_wdata;
      wr_strb_r    <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_hold_r     <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dmaec_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? dmaec_pkg::RESP_OKAY : dmaec_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // one-cycle write strobes per register, lane 0 gating the channel control, status and mask ones
  logic ev_wr;
  logic cc_wr;
  logic st_wr;
  logic mk_wr;
  logic ss_wr;
  logic ds_wr;

  assign ev_wr = wr_fire & (wr_addr_r == dmaec_pkg::OFS_EVENT_CTRL);
  assign cc_wr = wr_fire & (wr_addr_r == dmaec_pkg::OFS_CHAN_CTRL) & wr_strb_r[0];
  assign st_wr = wr_fire & (wr_addr_r == dmaec_pkg::OFS_IRQ_STATUS) & wr_strb_r[0];
  assign mk_wr = wr_fire & (wr_addr_r == dmaec_pkg::OFS_IRQ_MASK) & wr_strb_r[0];
  assign ss_wr = wr_fire & (wr_addr_r == dmaec_pkg::OFS_SRC_SIZE);
  assign ds_wr = wr_fire & (wr_addr_r == dmaec_pkg::OFS_DST_SIZE);

  ////////////////////////////////////////////////////////////////////////////
  // event control register

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      abort_sel_r <= dmaec_pkg::SEL_RST;
      start_sel_r <= dmaec_pkg::SEL_RST;
      pat_en_r    <= 1'b0;
      start_en_r  <= 1'b0;
      abort_en_r  <= 1'b0;
    end else if (ev_wr) begin
      if (wr_strb_r[2]) begin
        abort_sel_r <= wr_data_r[dmaec_pkg::ABORT_SEL_LSB +: 8];
      end
      if (wr_strb_r[1]) begin
        start_sel_r <= wr_data_r[dmaec_pkg::START_SEL_LSB +: 8];
      end
      if (wr_strb_r[0]) begin
        pat_en_r   <= wr_data_r[dmaec_pkg::PAT_EN_BIT];
        start_en_r <= wr_data_r[dmaec_pkg::START_EN_BIT];
        abort_en_r <= wr_data_r[dmaec_pkg::ABORT_EN_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event resolution

  logic sw_force;
  logic sw_abort;
  logic start_irq_hit;
  logic abort_irq_hit;
  logic pat_abort;
  logic abort_hit;
  logic start_hit;

  // force and abort are write actions only, nothing is stored
  assign sw_force      = ev_wr & wr_strb_r[0] & wr_data_r[dmaec_pkg::FORCE_BIT];
  assign sw_abort      = ev_wr & wr_strb_r[0] & wr_data_r[dmaec_pkg::ABORT_BIT];
  assign start_irq_hit = irq_evt.valid & start_en_r & (irq_evt.num == start_sel_r);
  assign abort_irq_hit = irq_evt.valid & abort_en_r & (irq_evt.num == abort_sel_r);
  assign pat_abort     = pat_en_r & eng.pattern_hit;
  assign abort_hit     = abort_irq_hit | sw_abort | pat_abort;
  // a disabled channel ignores start requests
  assign start_hit     = chan_en_r & (start_irq_hit | sw_force) & ~abort_hit;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= dmaec_pkg::CH_IDLE;
    end else begin
      unique case (state_r)
        dmaec_pkg::CH_IDLE: begin
          if (start_hit) begin
            state_r <= dmaec_pkg::CH_BUSY;
          end
        end
        dmaec_pkg::CH_BUSY: begin
          if (abort_hit || (eng.cell_done && !start_hit)) begin
            state_r <= dmaec_pkg::CH_IDLE;
          end
        end
      endcase
    end
  end

  // hardware clear of the enable wins over a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_en_r <= 1'b0;
    end else if (pat_abort) begin
      chan_en_r <= 1'b0;
    end else if (cc_wr) begin
      chan_en_r <= wr_data_r[dmaec_pkg::CHAN_EN_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_r <= '0;
    end else begin
      ctl_r.start          <= start_hit;
      ctl_r.abort          <= abort_hit;
      ctl_r.channel_enable <= chan_en_r & ~pat_abort;
      ctl_r.busy           <= (state_r == dmaec_pkg::CH_BUSY);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte pointers

  dmaec_ptr u_src_ptr (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (pat_en_r & eng.pattern_hit),
    .adv     (eng.src_adv),
    .bytes   (eng.src_bytes),
    .size    (src_size_r),
    .ptr_r   (src_ptr),
    .wrap_r  (src_wrap)
  );

  dmaec_ptr u_dst_ptr (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (1'b0),
    .adv     (eng.dst_adv),
    .bytes   (eng.dst_bytes),
    .size    (dst_size_r),
    .ptr_r   (dst_ptr),
    .wrap_r  (dst_wrap)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_size_r <= dmaec_pkg::SIZE_RST;
      dst_size_r <= dmaec_pkg::SIZE_RST;
    end else begin
      if (ss_wr && wr_strb_r[0]) src_size_r[7:0]  <= wr_data_r[7:0];
      if (ss_wr && wr_strb_r[1]) src_size_r[15:8] <= wr_data_r[15:8];
      if (ds_wr && wr_strb_r[0]) dst_size_r[7:0]  <= wr_data_r[7:0];
      if (ds_wr && wr_strb_r[1]) dst_size_r[15:8] <= wr_data_r[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status, mask and output

  logic [dmaec_pkg::IRQ_W-1:0] st_set;
  logic [dmaec_pkg::IRQ_W-1:0] st_clr;

  always_comb begin
    st_set = '0;
    st_set[dmaec_pkg::ST_ABORT_FLAG] = abort_irq_hit;
    st_set[dmaec_pkg::ST_STARTED]    = start_hit;
    st_set[dmaec_pkg::ST_PAT_ABORT]  = pat_abort;
    st_set[dmaec_pkg::ST_CELL_DONE]  = eng.cell_done;
    st_set[dmaec_pkg::ST_SRC_WRAP]   = src_wrap;
    st_set[dmaec_pkg::ST_DST_WRAP]   = dst_wrap;
  end

  assign st_clr = st_wr ? wr_data_r[dmaec_pkg::IRQ_W-1:0] : '0;

  // a new event in the clearing cycle survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= dmaec_pkg::IRQ_RST;
    end else begin
      status_r <= (status_r & ~st_clr) | st_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_r <= dmaec_pkg::IRQ_RST;
    end else if (mk_wr) begin
      mask_r <= wr_data_r[dmaec_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_r & mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi read channel

  logic [31:0] rd_mux;
  logic        rd_ok;

  always_comb begin
    rd_mux = 32'h00000000;
    rd_ok  = 1'b1;
    unique case (s_axi_araddr)
      dmaec_pkg::OFS_EVENT_CTRL: begin
        // force and abort read zero, low and top bits unimplemented
        rd_mux[dmaec_pkg::ABORT_SEL_LSB +: 8] = abort_sel_r;
        rd_mux[dmaec_pkg::START_SEL_LSB +: 8] = start_sel_r;
        rd_mux[dmaec_pkg::PAT_EN_BIT]         = pat_en_r;
        rd_mux[dmaec_pkg::START_EN_BIT]       = start_en_r;
        rd_mux[dmaec_pkg::ABORT_EN_BIT]       = abort_en_r;
      end
      dmaec_pkg::OFS_SRC_PTR:    rd_mux[dmaec_pkg::PTR_W-1:0] = src_ptr;
      dmaec_pkg::OFS_DST_PTR:    rd_mux[dmaec_pkg::PTR_W-1:0] = dst_ptr;
      dmaec_pkg::OFS_CHAN_CTRL: begin
        rd_mux[dmaec_pkg::CHAN_EN_BIT]   = chan_en_r;
        rd_mux[dmaec_pkg::CHAN_BUSY_BIT] = (state_r == dmaec_pkg::CH_BUSY);
      end
      dmaec_pkg::OFS_IRQ_STATUS: rd_mux[dmaec_pkg::IRQ_W-1:0] = status_r;
      dmaec_pkg::OFS_IRQ_MASK:   rd_mux[dmaec_pkg::IRQ_W-1:0] = mask_r;
      dmaec_pkg::OFS_SRC_SIZE:   rd_mux[dmaec_pkg::PTR_W-1:0] = src_size_r;
      dmaec_pkg::OFS_DST_SIZE:   rd_mux[dmaec_pkg::PTR_W-1:0] = dst_size_r;
      default:                   rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= dmaec_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_ok ? dmaec_pkg::RESP_OKAY : dmaec_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

endmodule

// ---- dmaec_far.sv ----
// far-side model: interrupt sources and the channel transfer engine
// assumes the block's control outputs share aclk; the bench calls the tasks
`timescale 1ns/10ps
module dmaec_far (
  // clock
  input  wire logic                     aclk,
  // towards the block
  output dmaec_pkg::dmaec_irq_evt_s     irq_evt,
  output dmaec_pkg::dmaec_eng_s         eng,
  input  wire dmaec_pkg::dmaec_ctl_s    ctl_r
);
  int left;

  initial begin
    irq_evt = '0;
    eng     = '0;
    left    = 0;
  end

  //////////////////////////////////////////
  // a started cell finishes after a random delay, prompt or slow
  always @(posedge aclk) begin
    eng.cell_done <= 1'b0;
    if (ctl_r.start === 1'b1)
      left <= $urandom_range(1, 12);
    else if (ctl_r.abort === 1'b1)
      left <= 0;
    else if (left == 1) begin
      eng.cell_done <= 1'b1;
      left          <= 0;
    end else if (left > 1)
      left <= left - 1;
  end

  task automatic fire(input logic [7:0] n);
    @(posedge aclk);
    irq_evt <= {1'b1, n};
    @(posedge aclk);
    // a stale number is scrambled, never left standing
    irq_evt <= {1'b0, ~n};
  endtask

  task automatic move(input logic [15:0] s, input logic [15:0] d);
    @(posedge aclk);
    eng.src_adv   <= 1'b1;
    eng.src_bytes <= s;
    eng.dst_adv   <= 1'b1;
    eng.dst_bytes <= d;
    @(posedge aclk);
    eng.src_adv   <= 1'b0;
    eng.src_bytes <= ~s;
    eng.dst_adv   <= 1'b0;
    eng.dst_bytes <= ~d;
  endtask

  task automatic hit();
    @(posedge aclk);
    eng.pattern_hit <= 1'b1;
    @(posedge aclk);
    eng.pattern_hit <= 1'b0;
  endtask
endmodule

// ---- dmaec_checker.sv ----
// assertions on the ports of the event control block
// assumes one clock domain; bound to every dmaec_top
`timescale 1ns/10ps
module dmaec_checker (
  // clock and reset
  input wire logic                      aclk,
  input wire logic                      aresetn,
  // register bus
  input wire logic                      s_axi_awvalid,
  input wire logic                      s_axi_awready,
  input wire logic                      s_axi_wvalid,
  input wire logic                      s_axi_wready,
  input wire logic                      s_axi_bvalid,
  input wire logic                      s_axi_arvalid,
  input wire logic                      s_axi_arready,
  input wire logic                      s_axi_rvalid,
  input wire logic [31:0]               s_axi_rdata,
  // events, engine and control
  input wire dmaec_pkg::dmaec_irq_evt_s irq_evt,
  input wire dmaec_pkg::dmaec_eng_s     eng,
  input wire dmaec_pkg::dmaec_ctl_s     ctl_r
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_answer;
    !s_axi_awready ##1 s_axi_bvalid;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  //////////////////////////////////////////
  write_answer_a: assert property (wr_taken |=> wr_answer)
    else $error("write answer late");
  read_answer_a: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  abort_beats_start_a: assert property (ctl_r.abort |-> !ctl_r.start)
    else $error("start beside abort");
  start_enabled_a: assert property (ctl_r.start |-> ctl_r.channel_enable)
    else $error("start on disabled channel");
  start_cause_a: assert property (ctl_r.start |-> $past(irq_evt.valid) || $rose(s_axi_bvalid))
    else $error("start without cause");
  abort_cause_a: assert property (ctl_r.abort |-> $past(irq_evt.valid) || $past(eng.pattern_hit)
    || $rose(s_axi_bvalid))
    else $error("abort without cause");
  enable_drop_a: assert property ($fell(ctl_r.channel_enable) |-> ctl_r.abort || $past(s_axi_bvalid))
    else $error("enable dropped alone");
  abort_idle_a: assert property (ctl_r.abort |=> !ctl_r.busy)
    else $error("busy after abort");
  busy_rise_a: assert property ($rose(ctl_r.busy) |-> $past(ctl_r.start))
    else $error("busy without start");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:24] == 8'h00)
    else $error("upper read bits set");
endmodule

bind dmaec_top dmaec_checker i_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata,
  .irq_evt, .eng, .ctl_r
);

// ---- dmaec_top_bench.sv ----
// self-checking bench of the dma channel event control block
// assumes the package, design, checker and far-side model compiled first
`timescale 1ns/10ps
module dmaec_top_bench;
  logic                      aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic                      arvalid, arready, rvalid, rready, irq;
  logic [7:0]                awaddr, araddr, sa, sb;
  logic [31:0]               wdata, rdata, d;
  logic [3:0]                wstrb;
  logic [1:0]                bresp, rresp, r;
  logic [15:0]               sp, dp, ss, ds, b1, b2;
  dmaec_pkg::dmaec_irq_evt_s evt;
  dmaec_pkg::dmaec_eng_s     eng;
  dmaec_pkg::dmaec_ctl_s     ctl;
  int                        n_mismatch, n_compared, n_st, n_ab, n_cyc;

  dmaec_top i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_evt(evt),
    .eng(eng), .ctl_r(ctl), .irq_r(irq));
  dmaec_far i_far (.aclk(aclk), .irq_evt(evt), .eng(eng), .ctl_r(ctl));

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // pulse counters and the hang limit
  always @(posedge aclk) begin
    n_cyc++;
    if (ctl.start === 1'b1) n_st++;
    if (ctl.abort === 1'b1) n_ab++;
    if (n_cyc == 40000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  //////////////////////////////////////////
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic w(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask

  // configure, fire one interrupt number, compare start and abort pulses
  task automatic ev(input logic [31:0] c, input logic [7:0] n, input int es, input int ea);
    int s0;
    int a0;
    s0 = n_st;
    a0 = n_ab;
    wr(8'h00, c);
    i_far.fire(n);
    w(3);
    chk(n_st - s0, es);
    chk(n_ab - a0, ea);
  endtask

  // expected pointer: a size of zero spans the full 64 kbytes
  function automatic logic [15:0] nx(input logic [15:0] p, input logic [15:0] b, input logic [15:0] s);
    logic [16:0] t;
    t = {1'b0, p} + {1'b0, b};
    return (t >= ((s == 16'h0) ? 17'h10000 : {1'b0, s})) ? 16'h0 : t[15:0];
  endfunction

  //////////////////////////////////////////
  initial begin
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb   = 4'hf;
    aresetn = 1'b0;
    d       = $urandom(32'h3d43);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rc(dmaec_pkg::OFS_EVENT_CTRL, 32'h00ffff00);
    rc(dmaec_pkg::OFS_SRC_PTR, 32'h0);
    rc(dmaec_pkg::OFS_DST_PTR, 32'h0);
    rd(8'h20);
    chk(r, dmaec_pkg::RESP_SLVERR);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 32'hffffffff : $urandom;
      wr(8'h00, d);
      rc(8'h00, d & 32'h00ffff38);
    end
    wr(8'h04, 32'hffffffff);
    chk(r, dmaec_pkg::RESP_OKAY);
    rc(8'h04, 32'h0);
    wr(8'h0c, 32'h1);
    for (int k = 0; k < 3; k++) begin
      sa = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
      sb = sa ^ 8'($urandom_range(1, 255));
      ev({8'h0, sa, sb, 8'h10}, sb, 1, 0);
      ev({8'h0, sa, sb, 8'h00}, sb, 0, 0);
      ev({8'h0, sa, sb, 8'h10}, sa, 0, 0);
      ev({8'h0, sa, sb, 8'h08}, sa, 0, 1);
      ev({8'h0, sa, sa, 8'h18}, sa, 0, 1);
      ev({8'h0, sa, sb, 8'h80}, sb, 1, 0);
      ev({8'h0, sa, sb, 8'h40}, sb, 0, 1);
    end
    // a disabled channel ignores both the start interrupt and a forced start
    wr(8'h0c, 32'h0);
    ev({8'h0, sa, sb, 8'h90}, sb, 0, 0);
    wr(8'h0c, 32'h1);
    wr(8'h10, 32'h3f);
    wr(8'h14, 32'h1);
    ev({8'h0, sa, sb, 8'h40}, sb, 0, 1);
    rd(8'h10);
    chk(d[0], 1'b0);
    ev({8'h0, sa, sb, 8'h08}, sa, 0, 1);
    rd(8'h10);
    chk(d[0], 1'b1);
    chk(irq, 1'b1);
    wr(8'h10, 32'h1);
    w(2);
    chk(irq, 1'b0);
    wr(8'h14, 32'h0);
    ev({8'h0, sa, sb, 8'h08}, sa, 0, 1);
    chk(irq, 1'b0);
    $display("test events done");
    ss = 16'($urandom_range(200, 900));
    ds = 16'h0;
    wr(8'h18, {16'h0, ss});
    wr(8'h1c, {16'h0, ds});
    sp = 16'h0;
    dp = 16'h0;
    for (int i = 0; i < 12; i++) begin
      b1 = 16'($urandom_range(1, 300));
      b2 = (i == 0) ? 16'hffff : 16'($urandom_range(1, 40000));
      i_far.move(b1, b2);
      sp = nx(sp, b1, ss);
      dp = nx(dp, b2, ds);
      rc(8'h04, {16'h0, sp});
      rc(8'h08, {16'h0, dp});
    end
    $display("test pointers done");
    wr(8'h00, 32'h20);
    i_far.move(16'h5, 16'h0);
    d = n_ab;
    i_far.hit();
    w(3);
    chk(n_ab - d, 1);
    rc(8'h04, 32'h0);
    rc(8'h0c, 32'h0);
    wr(8'h0c, 32'h1);
    wr(8'h00, 32'h0);
    i_far.move(16'h5, 16'h0);
    sp = nx(16'h0, 16'h5, ss);
    d = n_ab;
    i_far.hit();
    w(3);
    chk(n_ab - d, 0);
    rc(8'h04, {16'h0, sp});
    rc(8'h0c, 32'h1);
    $display("test pattern done");
    give_verdict();
  end
endmodule
